// ---- hdl/quad_counter.sv ----
// Quadrature decoder with x4 counting and optional A/B exchange.
// Assumes encoder pins are asynchronous to clk_sys.
`timescale 1ns/1ps
module quad_counter (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    // Encoder pins and config
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic swap_ab,
    // Position
    output logic signed [servo_loop_pkg::POS_W-1:0] count
);
    import servo_loop_pkg::*;

    logic [1:0] a_sync_q;
    logic [1:0] b_sync_q;
    logic a_prev_q;
    logic b_prev_q;
    logic signed [POS_W-1:0] count_q;
    wire a_now = swap_ab ? b_sync_q[1] : a_sync_q[1];
    wire b_now = swap_ab ? a_sync_q[1] : b_sync_q[1];
    // One channel changing is a count; both at once is a lost state, ignored
    wire step = (a_now ^ a_prev_q) ^ (b_now ^ b_prev_q);
    wire up = a_now ^ b_prev_q;

    // Two-stage synchronisers, then edge history
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            a_sync_q <= 2'h0;
            b_sync_q <= 2'h0;
            a_prev_q <= 1'b0;
            b_prev_q <= 1'b0;
        end else if (clk_en) begin
            a_sync_q <= {a_sync_q[0], enc_a};
            b_sync_q <= {b_sync_q[0], enc_b};
            a_prev_q <= a_now;
            b_prev_q <= b_now;
        end
    end

    // Swapping channels reverses counting direction
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count_q <= '0;
        end else if (clk_en && step) begin
            count_q <= up ? count_q + 32'sh0000_0001 : count_q - 32'sh0000_0001;
        end
    end

    assign count = count_q;

endmodule : quad_counter

// ---- hdl/servo_loop_pkg.sv ----
// Constants, register map and types for the servo position loop.
// Assumes a 40 MHz system clock and a plain strobed register port.
package servo_loop_pkg;

    // Clock and sampling times
    localparam int CLK_PERIOD_NS = 25;
    localparam int LOOP_1MS_NS = 1_000_000;
    localparam int LOOP_500US_NS = 500_000;
    localparam int LOOP_200US_NS = 200_000;
    localparam int LOOP_100US_NS = 100_000;
    localparam int LOOP_1MS_CYC = LOOP_1MS_NS / CLK_PERIOD_NS;
    localparam int LOOP_500US_CYC = LOOP_500US_NS / CLK_PERIOD_NS;
    localparam int LOOP_200US_CYC = LOOP_200US_NS / CLK_PERIOD_NS;
    localparam int LOOP_100US_CYC = LOOP_100US_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    // Widths
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int GAIN_W = 16;
    localparam int POS_W = 32;
    localparam int ERR_W = 24;
    localparam int DAC_W = 16;
    localparam int ACC_W = 48;
    localparam int FRAC_BITS = 8;
    localparam int AXES = 2;

    // Full scale and percent scaling: code = pct * PCT_MUL >>> PCT_SHIFT
    localparam logic signed [DAC_W-1:0] FULL_SCALE = 16'sh7FFF;
    localparam logic signed [DAC_W-1:0] PCT_MUL = 16'sh51EB;
    localparam int PCT_SHIFT = 6;
    localparam logic [7:0] PCT_MAX = 8'h64;

    // Register index inside an axis block; address bit 5 selects the axis
    localparam int AXIS_SEL_BIT = 5;
    localparam logic [4:0] OFS_PROP = 5'h00;
    localparam logic [4:0] OFS_VELFB = 5'h01;
    localparam logic [4:0] OFS_DERIV = 5'h02;
    localparam logic [4:0] OFS_INT = 5'h03;
    localparam logic [4:0] OFS_INTLIM = 5'h04;
    localparam logic [4:0] OFS_INTMODE = 5'h05;
    localparam logic [4:0] OFS_VELFF = 5'h06;
    localparam logic [4:0] OFS_ACCFF = 5'h07;
    localparam logic [4:0] OFS_DEM_POS = 5'h08;
    localparam logic [4:0] OFS_DEM_VEL = 5'h09;
    localparam logic [4:0] OFS_DEM_ACC = 5'h0A;
    localparam logic [4:0] OFS_CMD = 5'h0B;
    localparam logic [4:0] OFS_ENC_CFG = 5'h0C;
    localparam logic [4:0] OFS_MEAS_POS = 5'h0D;
    localparam logic [4:0] OFS_FERR = 5'h0E;
    localparam logic [4:0] OFS_DEMAND = 5'h0F;
    localparam logic [4:0] OFS_MEAS_VEL = 5'h10;
    localparam logic [4:0] OFS_PERIOD = 5'h14;

    // Command register fields
    localparam int CMD_MODE_LSB = 0;
    localparam int CMD_PCT_LSB = 8;

    // Reset values
    localparam logic [GAIN_W-1:0] RST_GAIN = 16'h0000;
    localparam logic [7:0] RST_INTLIM = 8'h64;

    typedef enum logic [1:0] {CMD_HALT, CMD_SERVO, CMD_TORQUE} cmd_mode_t;
    typedef enum logic [1:0] {INT_ALWAYS, INT_OFF, INT_CONST_VEL} int_mode_t;
    typedef enum logic [1:0] {PER_1MS, PER_500US, PER_200US, PER_100US} period_sel_t;

endpackage : servo_loop_pkg

// ---- hdl/servo_position_loop.sv ----
// Two-axis sampled servo position loop with PID, feedforward and torque test.
// Assumes a host on the register port supplies the demand trajectory.
//
// Behaviour
// - Compare demanded and measured position once per sample, default 1 ms.
// - Sample period selectable: 1 ms, 500 us, 200 us or 100 us.
// - Each sample compute a new demand that reduces the following error.
// - Proportional term is following error times proportional gain.
// - Integral term accumulates following error sample after sample.
// - Integral magnitude clamped to a percentage of full-scale demand.
// - Integral mode: always, never, or only at constant demanded velocity.
// - Velocity feedback subtracts demand proportional to measured velocity.
// - Derivative of error matches velocity feedback when feedback equals feedforward.
// - Velocity feedforward adds demand from demanded speed, outside the loop.
// - Acceleration feedforward adds demand from demanded acceleration.
// - Torque command drives demand to a signed percentage of full scale.
// - Halt command returns demand to zero.
// - Axis 0 uses demand 0 and encoder 0; axis 1 uses demand 1, encoder 1.
// - Encoder config can swap A and B, reversing position and velocity.
// - All gains reset to zero so demand stays zero until programmed.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module servo_position_loop #(
    parameter logic [15:0] CYC_1MS = 16'(servo_loop_pkg::LOOP_1MS_CYC),
    parameter logic [15:0] CYC_500US = 16'(servo_loop_pkg::LOOP_500US_CYC),
    parameter logic [15:0] CYC_200US = 16'(servo_loop_pkg::LOOP_200US_CYC),
    parameter logic [15:0] CYC_100US = 16'(servo_loop_pkg::LOOP_100US_CYC)
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    // Register port
    input wire logic [servo_loop_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [servo_loop_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [servo_loop_pkg::DATA_W-1:0] reg_rdata,
    // Encoder pins
    input wire logic [servo_loop_pkg::AXES-1:0] enc_a,
    input wire logic [servo_loop_pkg::AXES-1:0] enc_b,
    // Demand outputs and sample strobe
    output logic signed [servo_loop_pkg::DAC_W-1:0] demand_output_zero,
    output logic signed [servo_loop_pkg::DAC_W-1:0] demand_output_one,
    output logic sample_tick
);
    import servo_loop_pkg::*;

    // Control registers
    logic signed [GAIN_W-1:0] kp_q [AXES];
    logic signed [GAIN_W-1:0] kv_q [AXES];
    logic signed [GAIN_W-1:0] kd_q [AXES];
    logic signed [GAIN_W-1:0] ki_q [AXES];
    logic signed [GAIN_W-1:0] kvff_q [AXES];
    logic signed [GAIN_W-1:0] kacc_q [AXES];
    logic [7:0] ilim_q [AXES];
    int_mode_t imode_q [AXES];
    cmd_mode_t cmd_q [AXES];
    logic signed [7:0] tq_q [AXES];
    logic signed [POS_W-1:0] dpos_q [AXES];
    logic signed [ERR_W-1:0] dvel_q [AXES];
    logic signed [ERR_W-1:0] dacc_q [AXES];
    logic swap_q [AXES];
    period_sel_t period_q;
    // Loop state
    logic [CNT_W-1:0] cnt_q;
    logic tick_q;
    logic signed [POS_W-1:0] meas_prev_q [AXES];
    logic signed [ERR_W-1:0] err_prev_q [AXES];
    logic signed [ERR_W-1:0] dvel_prev_q [AXES];
    logic signed [ACC_W-1:0] integ_q [AXES];
    logic signed [DAC_W-1:0] demand_q [AXES];
    logic signed [ERR_W-1:0] ferr_q [AXES];
    logic signed [ERR_W-1:0] vel_q [AXES];
    logic [DATA_W-1:0] rdata_q;
    // Per-axis combinational results
    logic signed [POS_W-1:0] meas [AXES];
    logic signed [ERR_W-1:0] err [AXES];
    logic signed [ERR_W-1:0] vmeas [AXES];
    logic signed [ACC_W-1:0] integ_d [AXES];
    logic signed [ACC_W-1:0] lim [AXES];
    logic signed [DAC_W-1:0] servo_code [AXES];
    logic signed [DAC_W-1:0] torque_code [AXES];
    logic signed [DAC_W-1:0] demand_d [AXES];

    // Saturate a wide difference into the error width
    function automatic logic signed [ERR_W-1:0] sat_err(input logic signed [POS_W:0] x);
        logic signed [POS_W:0] hi;
        hi = (POS_W+1)'(2 ** (ERR_W - 1) - 1);
        if (x > hi) sat_err = ERR_W'(hi);
        else if (x < -hi) sat_err = ERR_W'(-hi);
        else sat_err = x[ERR_W-1:0];
    endfunction : sat_err

    // Percent to DAC code; clamped to 100, so +100 gives full scale and -100 gives -32768
    function automatic logic signed [DAC_W-1:0] pct_code(input logic signed [7:0] p);
        logic signed [7:0] c;
        logic signed [31:0] m;
        c = (p > $signed(PCT_MAX)) ? $signed(PCT_MAX) : (p < -$signed(PCT_MAX)) ? -$signed(PCT_MAX) : p;
        m = 32'(c) * 32'(PCT_MUL);
        pct_code = DAC_W'(m >>> PCT_SHIFT);
    endfunction : pct_code

    // Register decode
    wire wr_en = clk_en && reg_wr;
    wire [4:0] idx = reg_addr[4:0];
    wire wr_period = wr_en && idx == OFS_PERIOD;
    wire [15:0] period_lim = period_q == PER_1MS ? CYC_1MS : period_q == PER_500US ? CYC_500US :
                             period_q == PER_200US ? CYC_200US : CYC_100US;
    wire do_sample = clk_en && tick_q;

    // Sample tick; a shortened period takes effect at once
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (clk_en) begin
            tick_q <= cnt_q >= period_lim - 16'h0001;
            cnt_q <= (cnt_q >= period_lim - 16'h0001) ? '0 : cnt_q + 16'h0001;
        end
    end

    // Period select is shared by both axes
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) period_q <= PER_1MS;
        else if (wr_period) period_q <= period_sel_t'(reg_wdata[1:0]);
    end

    for (genvar ax = 0; ax < AXES; ax++) begin : g_axis
        wire wr_ax = wr_en && reg_addr[AXIS_SEL_BIT] == 1'(ax);
        wire signed [POS_W:0] e_full = (POS_W+1)'(dpos_q[ax]) - (POS_W+1)'(meas[ax]);
        wire signed [POS_W:0] v_full = (POS_W+1)'(meas[ax]) - (POS_W+1)'(meas_prev_q[ax]);
        wire signed [POS_W:0] de_full = (POS_W+1)'(err[ax]) - (POS_W+1)'(err_prev_q[ax]);
        wire signed [ERR_W-1:0] de = sat_err(de_full);
        wire const_vel = dvel_q[ax] == dvel_prev_q[ax];
        wire int_on = imode_q[ax] == INT_ALWAYS || (imode_q[ax] == INT_CONST_VEL && const_vel);
        wire signed [ACC_W-1:0] i_sum = integ_q[ax] + ACC_W'(ki_q[ax] * err[ax]);
        wire signed [ACC_W-1:0] t_p = ACC_W'(kp_q[ax] * err[ax]);
        wire signed [ACC_W-1:0] t_v = ACC_W'(kv_q[ax] * vmeas[ax]);
        wire signed [ACC_W-1:0] t_d = ACC_W'(kd_q[ax] * de);
        wire signed [ACC_W-1:0] t_ff = ACC_W'(kvff_q[ax] * dvel_q[ax]);
        wire signed [ACC_W-1:0] t_a = ACC_W'(kacc_q[ax] * dacc_q[ax]);
        wire signed [ACC_W-1:0] t_i = int_on ? integ_d[ax] : '0;
        wire signed [ACC_W-1:0] sum = t_p + t_i - t_v + t_d + t_ff + t_a;
        wire signed [ACC_W-1:0] sum_s = sum >>> FRAC_BITS;
        wire signed [ACC_W-1:0] fs = ACC_W'(FULL_SCALE);

        // Axis n is fixed to encoder n and demand output n
        quad_counter u_enc (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .clk_en(clk_en),
            .enc_a(enc_a[ax]),
            .enc_b(enc_b[ax]),
            .swap_ab(swap_q[ax]),
            .count(meas[ax])
        );

        // Error, velocity, limit and demand selection
        assign err[ax] = sat_err(e_full);
        assign vmeas[ax] = sat_err(v_full);
        // Limit field is unsigned; clamp before the signed percent scaling
        assign lim[ax] = ACC_W'(pct_code(ilim_q[ax] > PCT_MAX ? PCT_MAX : ilim_q[ax])) <<< FRAC_BITS;
        // Integrator holds outside constant velocity and empties when off
        assign integ_d[ax] = imode_q[ax] == INT_OFF ? '0 : !int_on ? integ_q[ax] :
                             i_sum > lim[ax] ? lim[ax] : i_sum < -lim[ax] ? -lim[ax] : i_sum;
        assign servo_code[ax] = sum_s > fs ? FULL_SCALE : sum_s < -fs ? -FULL_SCALE
                                : sum_s[DAC_W-1:0];
        assign torque_code[ax] = pct_code(tq_q[ax]);
        assign demand_d[ax] = cmd_q[ax] == CMD_SERVO ? servo_code[ax] :
                              cmd_q[ax] == CMD_TORQUE ? torque_code[ax] : '0;

        // Gains start at zero
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                kp_q[ax] <= RST_GAIN;
                kv_q[ax] <= RST_GAIN;
                kd_q[ax] <= RST_GAIN;
                ki_q[ax] <= RST_GAIN;
                kvff_q[ax] <= RST_GAIN;
                kacc_q[ax] <= RST_GAIN;
            end else if (wr_ax) begin
                if (idx == OFS_PROP) kp_q[ax] <= reg_wdata[GAIN_W-1:0];
                if (idx == OFS_VELFB) kv_q[ax] <= reg_wdata[GAIN_W-1:0];
                if (idx == OFS_DERIV) kd_q[ax] <= reg_wdata[GAIN_W-1:0];
                if (idx == OFS_INT) ki_q[ax] <= reg_wdata[GAIN_W-1:0];
                if (idx == OFS_VELFF) kvff_q[ax] <= reg_wdata[GAIN_W-1:0];
                if (idx == OFS_ACCFF) kacc_q[ax] <= reg_wdata[GAIN_W-1:0];
            end
        end

        // Modes, trajectory and encoder config
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                ilim_q[ax] <= RST_INTLIM;
                imode_q[ax] <= INT_ALWAYS;
                cmd_q[ax] <= CMD_SERVO;
                tq_q[ax] <= '0;
                dpos_q[ax] <= '0;
                dvel_q[ax] <= '0;
                dacc_q[ax] <= '0;
                swap_q[ax] <= 1'b0;
            end else if (wr_ax) begin
                if (idx == OFS_INTLIM) ilim_q[ax] <= reg_wdata[7:0];
                if (idx == OFS_INTMODE) imode_q[ax] <= int_mode_t'(reg_wdata[1:0]);
                if (idx == OFS_CMD) cmd_q[ax] <= cmd_mode_t'(reg_wdata[CMD_MODE_LSB +: 2]);
                if (idx == OFS_CMD) tq_q[ax] <= reg_wdata[CMD_PCT_LSB +: 8];
                if (idx == OFS_DEM_POS) dpos_q[ax] <= reg_wdata;
                if (idx == OFS_DEM_VEL) dvel_q[ax] <= reg_wdata[ERR_W-1:0];
                if (idx == OFS_DEM_ACC) dacc_q[ax] <= reg_wdata[ERR_W-1:0];
                if (idx == OFS_ENC_CFG) swap_q[ax] <= reg_wdata[0];
            end
        end

        // Loop state advances only on the sample tick
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                meas_prev_q[ax] <= '0;
                err_prev_q[ax] <= '0;
                dvel_prev_q[ax] <= '0;
                integ_q[ax] <= '0;
                demand_q[ax] <= '0;
                ferr_q[ax] <= '0;
                vel_q[ax] <= '0;
            end else if (do_sample) begin
                meas_prev_q[ax] <= meas[ax];
                err_prev_q[ax] <= err[ax];
                dvel_prev_q[ax] <= dvel_q[ax];
                // Halt and torque test discard the stored integral
                integ_q[ax] <= cmd_q[ax] == CMD_SERVO ? integ_d[ax] : '0;
                demand_q[ax] <= demand_d[ax];
                ferr_q[ax] <= err[ax];
                vel_q[ax] <= vmeas[ax];
            end
        end
    end

    // Read selection; unmapped indices read zero
    logic [DATA_W-1:0] rd_mux;
    wire rsel = reg_addr[AXIS_SEL_BIT];
    always_comb begin
        rd_mux = '0;
        unique case (idx)
            OFS_PROP: rd_mux = DATA_W'(unsigned'(kp_q[rsel]));
            OFS_VELFB: rd_mux = DATA_W'(unsigned'(kv_q[rsel]));
            OFS_DERIV: rd_mux = DATA_W'(unsigned'(kd_q[rsel]));
            OFS_INT: rd_mux = DATA_W'(unsigned'(ki_q[rsel]));
            OFS_INTLIM: rd_mux = DATA_W'(ilim_q[rsel]);
            OFS_INTMODE: rd_mux = DATA_W'(imode_q[rsel]);
            OFS_VELFF: rd_mux = DATA_W'(unsigned'(kvff_q[rsel]));
            OFS_ACCFF: rd_mux = DATA_W'(unsigned'(kacc_q[rsel]));
            OFS_DEM_POS: rd_mux = dpos_q[rsel];
            OFS_DEM_VEL: rd_mux = DATA_W'(dvel_q[rsel]);
            OFS_DEM_ACC: rd_mux = DATA_W'(dacc_q[rsel]);
            OFS_CMD: rd_mux = {16'h0000, tq_q[rsel], 6'h00, cmd_q[rsel]};
            OFS_ENC_CFG: rd_mux = DATA_W'(swap_q[rsel]);
            OFS_MEAS_POS: rd_mux = meas[rsel];
            OFS_FERR: rd_mux = DATA_W'(ferr_q[rsel]);
            OFS_DEMAND: rd_mux = DATA_W'(demand_q[rsel]);
            OFS_MEAS_VEL: rd_mux = DATA_W'(vel_q[rsel]);
            OFS_PERIOD: rd_mux = DATA_W'(period_q);
            default: rd_mux = '0;
        endcase
    end

    // Read data stands for one cycle only
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) rdata_q <= '0;
        else if (clk_en) rdata_q <= reg_rd ? rd_mux : '0;
    end

    assign reg_rdata = rdata_q;
    assign demand_output_zero = demand_q[0];
    assign demand_output_one = demand_q[1];
    assign sample_tick = tick_q;

    // Helper: enabled cycles since the last tick, and period writes since
    logic [CNT_W-1:0] gap_q;
    logic per_wr_q;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gap_q <= '0;
            per_wr_q <= 1'b1;
        end else if (clk_en) begin
            gap_q <= tick_q ? 16'h0001 : gap_q + 16'h0001;
            per_wr_q <= wr_period || (per_wr_q && !tick_q);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_tick_due;
        clk_en && cnt_q >= period_lim - 16'h0001 |=> tick_q;
    endproperty
    a_tick_due: assert property (p_tick_due) else $error("sample tick missed");

    property p_tick_spacing;
        clk_en && tick_q && !per_wr_q |-> gap_q == period_lim;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("sample spacing differs from period");

    property p_halt_zero;
        do_sample && cmd_q[0] == CMD_HALT |=> demand_q[0] == '0 && integ_q[0] == '0;
    endproperty
    a_halt_zero: assert property (p_halt_zero) else $error("halt left a demand");

    property p_torque_code;
        do_sample && cmd_q[0] == CMD_TORQUE |=> demand_q[0] == $past(torque_code[0]);
    endproperty
    a_torque_code: assert property (p_torque_code) else $error("torque demand wrong");

    property p_demand_sat;
        demand_q[0] <= FULL_SCALE && demand_q[0] >= -FULL_SCALE;
    endproperty
    a_demand_sat: assert property (p_demand_sat) else $error("demand beyond full scale");

    property p_int_clamp;
        do_sample && cmd_q[0] == CMD_SERVO |=> integ_q[0] <= $past(lim[0]) && integ_q[0] >= -$past(lim[0]);
    endproperty
    a_int_clamp: assert property (p_int_clamp) else $error("integral beyond limit");

    property p_int_off;
        do_sample && imode_q[0] == INT_OFF |=> integ_q[0] == '0;
    endproperty
    a_int_off: assert property (p_int_off) else $error("integral kept while off");

    property p_zero_gains;
        do_sample && kp_q[0] == '0 && kv_q[0] == '0 && kd_q[0] == '0 && integ_q[0] == '0 && ki_q[0] == '0
            && kvff_q[0] == '0 && kacc_q[0] == '0 && cmd_q[0] == CMD_SERVO |=> demand_q[0] == '0;
    endproperty
    a_zero_gains: assert property (p_zero_gains) else $error("demand with zero gains");

    // Sampled error then holds; periods of 3 or more cycles keep it steady
    property p_ferr_sampled;
        do_sample |=> ferr_q[0] == $past(err[0]) ##1 $stable(ferr_q[0]) [*2];
    endproperty
    a_ferr_sampled: assert property (p_ferr_sampled) else $error("following error not sampled");

    property p_vel_sampled;
        do_sample |=> vel_q[0] == $past(vmeas[0]) && meas_prev_q[0] == $past(meas[0]);
    endproperty
    a_vel_sampled: assert property (p_vel_sampled) else $error("measured velocity not sampled");

endmodule : servo_position_loop

// ---- sim/servo_far_side.sv ----
// Far-side model: quadrature encoders on the two servo motors.
// Assumes the bench calls move() between register accesses.
`timescale 1ns/1ps
module servo_far_side (
    // Clock
    input wire logic clk_sys,
    // Encoder pins
    output logic [1:0] enc_a,
    output logic [1:0] enc_b
);
    logic [1:0] ph0 = 2'h0;
    logic [1:0] ph1 = 2'h0;
    // Gray phase to pins; A leads B when moving forward
    assign enc_a = {ph1[1] ^ ph1[0], ph0[1] ^ ph0[0]};
    assign enc_b = {ph1[1], ph0[1]};
    // One edge per step, held 5 cycles so the synchroniser sees each state
    task automatic move(input int ax, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            if (ax == 0) ph0 <= ph0 + 2'h1;
            else ph1 <= ph1 + 2'h1;
            repeat (4) @(posedge clk_sys);
        end
        #1;
    endtask : move
endmodule : servo_far_side

// ---- sim/testbench.sv ----
// Self-checking bench for the servo loop through its register port.
// Assumes sample periods shortened to 40/20/8/4 cycles.
`timescale 1ns/1ps
module testbench;
    import servo_loop_pkg::*;
    localparam logic [15:0] PER [4] = '{16'h0028, 16'h0014, 16'h0008, 16'h0004};
    logic clk_sys;
    logic rstn;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic [AXES-1:0] enc_a;
    logic [AXES-1:0] enc_b;
    logic signed [DAC_W-1:0] dem0;
    logic signed [DAC_W-1:0] dem1;
    logic sample_tick;
    logic [DATA_W-1:0] rd_q;
    int fail_count = 0;
    int cmp_count = 0;
    int gap;
    servo_position_loop #(.CYC_1MS(PER[0]), .CYC_500US(PER[1]), .CYC_200US(PER[2]), .CYC_100US(PER[3])) uut (
        .clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enc_a(enc_a), .enc_b(enc_b),
        .demand_output_zero(dem0), .demand_output_one(dem1), .sample_tick(sample_tick));
    servo_far_side far (.clk_sys(clk_sys), .enc_a(enc_a), .enc_b(enc_b));
    // Verdict in one place
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Bus cycles end 1 ns past the sampling edge, so results are settled
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [5:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rd_q = reg_rdata;
    endtask : rd
    // Take the current tick if one is pending; outputs land one edge later
    task automatic tick;
        gap = 0;
        while (sample_tick !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            gap++;
            if (gap > 100) begin
                fail_count++;
                report_and_stop();
            end
        end
        @(posedge clk_sys);
        #1;
    endtask : tick
    function automatic int pct_exp(input int p);
        return (p * int'(PCT_MUL)) >>> PCT_SHIFT;
    endfunction : pct_exp
    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Main sequence
    initial begin
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(6'h00);
        chk(rd_q, 32'h0000_0000);
        rd(6'h04);
        chk(rd_q, 32'h0000_0064);
        wr(6'h11, 32'h0000_00FF);
        rd(6'h11);
        chk(rd_q, 32'h0000_0000);
        tick();
        chk(32'(dem0), 32'h0000_0000);
        for (int s = 0; s < 4; s++) begin
            wr(6'h14, 32'(s));
            tick();
            tick();
            chk(32'(gap), 32'(PER[s]) - 1);
        end
        wr(6'h14, 32'h0000_0000);
        // Torque both ways on each output, then halt
        for (int ax = 0; ax < 2; ax++) begin
            for (int p = -5; p <= 5; p += 10) begin
                wr({1'(ax), 5'h0B}, 32'h0000_0002 | 32'((p & 32'h0000_00FF) << 8));
                tick();
                chk(32'(ax ? dem1 : dem0), 32'(pct_exp(p)));
            end
            wr({1'(ax), 5'h0B}, 32'h0000_0000);
            tick();
            chk(32'(ax ? dem1 : dem0), 32'h0000_0000);
        end
        // Proportional path and saturation both ways
        wr(6'h0B, 32'h0000_0001);
        wr(6'h00, 32'h0000_0100);
        wr(6'h08, 32'h0000_0064);
        tick();
        chk(32'(dem0), 32'h0000_0064);
        rd(6'h0E);
        chk(rd_q, 32'h0000_0064);
        wr(6'h08, 32'h4000_0000);
        tick();
        chk(32'(dem0), 32'h0000_7FFF);
        wr(6'h08, 32'hC000_0000);
        tick();
        chk(32'(dem0), 32'hFFFF_8001);
        // Integral growth, clamp at 1 percent, then each mode
        wr(6'h00, 32'h0000_0000);
        wr(6'h08, 32'h0000_0064);
        wr(6'h04, 32'h0000_0001);
        wr(6'h03, 32'h0000_0100);
        tick();
        chk(32'(dem0), 32'h0000_0064);
        tick();
        chk(32'(dem0), 32'h0000_00C8);
        tick();
        tick();
        chk(32'(dem0), 32'(pct_exp(1)));
        wr(6'h05, 32'h0000_0001);
        tick();
        chk(32'(dem0), 32'h0000_0000);
        wr(6'h05, 32'h0000_0002);
        tick();
        chk(32'(dem0), 32'h0000_0064);
        wr(6'h09, 32'h0000_0005);
        tick();
        chk(32'(dem0), 32'h0000_0000);
        // Feedforward terms with integral off
        wr(6'h05, 32'h0000_0001);
        wr(6'h06, 32'h0000_0100);
        tick();
        chk(32'(dem0), 32'h0000_0005);
        wr(6'h07, 32'h0000_0100);
        wr(6'h0A, 32'h0000_0003);
        tick();
        chk(32'(dem0), 32'h0000_0008);
        // Encoder counts, then swapped channels count back
        far.move(0, 4);
        rd(6'h0D);
        chk(rd_q, 32'h0000_0004);
        wr(6'h0C, 32'h0000_0001);
        far.move(0, 4);
        rd(6'h0D);
        chk(rd_q, 32'h0000_0000);
        // Velocity feedback on the swapped encoder: 8 plus 4 counts back
        wr(6'h01, 32'h0000_0100);
        tick();
        far.move(0, 4);
        tick();
        chk(32'(dem0), 32'h0000_000C);
        // Derivative alone gives the same demand for the same motion
        wr(6'h01, 32'h0000_0000);
        wr(6'h02, 32'h0000_0100);
        tick();
        chk(32'(dem0), 32'h0000_0008);
        far.move(0, 4);
        tick();
        chk(32'(dem0), 32'h0000_000C);
        // Second encoder feeds axis 1 only
        far.move(1, 3);
        rd(6'h2D);
        chk(rd_q, 32'h0000_0003);
        rd(6'h0D);
        chk(rd_q, 32'hFFFF_FFF8);
        report_and_stop();
    end
endmodule : testbench
